// ===== hdl/ram_port_pkg.sv
// Register map, field layout and encodings of the RAM test data port
package ram_port_pkg;
  localparam logic [7:0] OFS_SELECT     = 8'h40;
  localparam logic [7:0] OFS_COMMAND    = 8'h44;
  localparam logic [7:0] OFS_ADDRESS    = 8'h48;
  localparam logic [7:0] OFS_LOW_WORD   = 8'h4C;
  localparam logic [7:0] OFS_HIGH_BITS  = 8'h50;
  localparam int         READY_BIT      = 31;
  localparam int         TEST_EN_BIT    = 0;
  localparam int         CHOICE_LSB     = 1;
  localparam int         CHOICE_MSB     = 2;
  localparam int         CMD_WRITE_BIT  = 0;
  localparam int         ADDR_WIDTH     = 15;
  localparam int         HIGH_WIDTH     = 5;
  localparam int         DATA_WIDTH     = 32;
  localparam int         RAM_COUNT      = 4;
  localparam logic [14:0] ADDR_RESET    = 15'h0000;
  localparam logic [31:0] LOW_RESET     = 32'h0000_0000;
  localparam logic [4:0]  HIGH_RESET    = 5'h00;
  localparam logic        READY_RESET   = 1'b1;
  localparam logic        TEST_EN_RESET = 1'b0;
  localparam logic [1:0]  CHOICE_RESET  = 2'h0;
  localparam logic        CMD_RESET     = 1'b0;

  typedef enum logic [1:0] {
    RAM_FIFO_CONTROL = 2'h0,
    RAM_EEPROM_STORE = 2'h1,
    RAM_TRANSMIT_INFO = 2'h2,
    RAM_RECEIVE_INFO  = 2'h3
  } ram_choice_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT = 2'h3
  } port_state_type;
endpackage : ram_port_pkg

// ===== hdl/ram_access_sequencer.sv
// RAM test data port: APB registers, RAM routing and the access sequencer
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1: Software sets test enable before access
// RULE2: Port used only in test mode; here commands start accesses even with test enable clear
// RULE3: Ready flag bit 31, resets to one
// RULE4: Ready returns only after access completes
// RULE5: Choice field routes access to one RAM
// RULE6: Enable bit puts RAMs into test mode
// RULE7: Command write starts access, bit picks direction
// RULE8: Address and data programmed before command
// RULE9: Fifteen-bit word address, resets to zero
// RULE10: Low word carries write and read bits
// RULE11: Software polls ready before reading result
// RULE12: High bits carry upper bits of wide RAMs
// RULE13: Ready clears on accept, busy commands ignored
// RULE14: Narrow RAMs ignore high bits, read zero
////////////////////////////////////////////////////////////////////////////////
module internal_ram_test_data_port #(
  parameter int ADDR_WIDTH = ram_port_pkg::ADDR_WIDTH,
  parameter int DATA_WIDTH = ram_port_pkg::DATA_WIDTH,
  parameter int HIGH_WIDTH = ram_port_pkg::HIGH_WIDTH,
  parameter int RAM_COUNT  = ram_port_pkg::RAM_COUNT
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [7:0]                       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  ram_test_mode,
  output logic      [RAM_COUNT-1:0]             ram_enable,
  output logic                                  ram_req,
  output logic                                  ram_write,
  output logic      [ADDR_WIDTH-1:0]            ram_addr,
  output logic      [DATA_WIDTH+HIGH_WIDTH-1:0] ram_wdata,
  input  wire logic [DATA_WIDTH+HIGH_WIDTH-1:0] ram_rdata,
  input  wire logic                             ram_ack
);
  localparam int WORD_WIDTH = DATA_WIDTH + HIGH_WIDTH;

  // Wide RAMs use the high bits, narrow ones do not
  function automatic logic is_wide(input logic [1:0] choice);
    is_wide = (choice == ram_port_pkg::RAM_TRANSMIT_INFO) ||
              (choice == ram_port_pkg::RAM_RECEIVE_INFO);
  endfunction : is_wide

  //////////////////////////////////////////////////////////////////////////////
  // Registers and decode
  logic                  test_en_q;
  logic [1:0]            choice_q;
  logic                  cmd_write_q;
  logic [ADDR_WIDTH-1:0] addr_q;
  logic [DATA_WIDTH-1:0] low_q;
  logic [HIGH_WIDTH-1:0] high_q;
  logic                  op_write_q;
  logic [1:0]            op_choice_q;
  logic [ADDR_WIDTH-1:0] op_addr_q;
  logic [WORD_WIDTH-1:0] op_wdata_q;
  logic [31:0]           read_word;
  logic [HIGH_WIDTH-1:0] launch_high;
  logic [HIGH_WIDTH-1:0] capture_high;
  logic                  wr_access;
  logic                  rd_setup;
  logic                  wr_select;
  logic                  wr_command;
  logic                  wr_address;
  logic                  wr_low;
  logic                  wr_high;
  logic                  start;
  logic                  capture;
  logic                  capture_read;
  logic                  busy;
  logic                  port_ready;

  assign pready       = 1'b1;
  assign wr_access    = psel & penable & pready & pwrite;
  assign rd_setup     = psel & ~penable & ~pwrite;
  assign wr_select    = wr_access & (paddr == ram_port_pkg::OFS_SELECT);
  assign wr_command   = wr_access & (paddr == ram_port_pkg::OFS_COMMAND);
  assign wr_address   = wr_access & (paddr == ram_port_pkg::OFS_ADDRESS);
  assign wr_low       = wr_access & (paddr == ram_port_pkg::OFS_LOW_WORD);
  assign wr_high      = wr_access & (paddr == ram_port_pkg::OFS_HIGH_BITS);
  assign start        = wr_command & ~busy;                                   // [RULE13]
  assign port_ready   = ~busy;                                                // [RULE3]
  assign capture_read = capture & ~op_write_q;
  assign launch_high  = is_wide(choice_q) ? high_q : HIGH_WIDTH'(0);          // [RULE14]
  assign capture_high = is_wide(op_choice_q) ? ram_rdata[WORD_WIDTH-1:DATA_WIDTH]
                                             : HIGH_WIDTH'(0);                // [RULE12]
  assign ram_test_mode = test_en_q;                                           // [RULE6]
  assign ram_write     = op_write_q;
  assign ram_addr      = op_addr_q;                                           // [RULE9]
  assign ram_wdata     = op_wdata_q;

  genvar i;
  generate
    for (i = 0; i < RAM_COUNT; i++) begin : gen_route
      assign ram_enable[i] = (op_choice_q == 2'(i));                          // [RULE5]
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_en_q <= ram_port_pkg::TEST_EN_RESET;
      choice_q  <= ram_port_pkg::CHOICE_RESET;
    end else if (wr_select) begin
      test_en_q <= pwdata[ram_port_pkg::TEST_EN_BIT];                         // [RULE6]
      choice_q  <= pwdata[ram_port_pkg::CHOICE_MSB:ram_port_pkg::CHOICE_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= ram_port_pkg::ADDR_RESET;
    end else if (wr_address) begin
      addr_q <= pwdata[ADDR_WIDTH-1:0];                                       // [RULE9]
    end
  end

  // Captured read data wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= ram_port_pkg::LOW_RESET;
    end else if (capture_read) begin
      low_q <= ram_rdata[DATA_WIDTH-1:0];                                     // [RULE10]
    end else if (wr_low) begin
      low_q <= pwdata[DATA_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_q <= ram_port_pkg::HIGH_RESET;
    end else if (capture_read) begin
      high_q <= capture_high;                                                 // [RULE12]
    end else if (wr_high) begin
      high_q <= pwdata[HIGH_WIDTH-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command launch: operands frozen for the whole access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_write_q <= ram_port_pkg::CMD_RESET;
      op_write_q  <= ram_port_pkg::CMD_RESET;
      op_choice_q <= ram_port_pkg::CHOICE_RESET;
      op_addr_q   <= ram_port_pkg::ADDR_RESET;
      op_wdata_q  <= '0;
    end else if (start) begin
      cmd_write_q <= pwdata[ram_port_pkg::CMD_WRITE_BIT];                     // [RULE7]
      op_write_q  <= pwdata[ram_port_pkg::CMD_WRITE_BIT];
      op_choice_q <= choice_q;
      op_addr_q   <= addr_q;
      op_wdata_q  <= {launch_high, low_q};                                    // [RULE10]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read-back
  always_comb begin
    read_word = 32'h0000_0000;
    case (paddr)
      ram_port_pkg::OFS_SELECT: begin
        read_word[ram_port_pkg::READY_BIT]                           = port_ready;
        read_word[ram_port_pkg::CHOICE_MSB:ram_port_pkg::CHOICE_LSB] = choice_q;
        read_word[ram_port_pkg::TEST_EN_BIT]                         = test_en_q;
      end
      ram_port_pkg::OFS_COMMAND: begin
        read_word[ram_port_pkg::CMD_WRITE_BIT] = cmd_write_q;
      end
      ram_port_pkg::OFS_ADDRESS: begin
        read_word[ADDR_WIDTH-1:0] = addr_q;
      end
      ram_port_pkg::OFS_LOW_WORD: begin
        read_word[DATA_WIDTH-1:0] = low_q;
      end
      ram_port_pkg::OFS_HIGH_BITS: begin
        read_word[HIGH_WIDTH-1:0] = high_q;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // Read data latched in the setup cycle, stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= read_word;
    end
  end

  ram_access_sequencer ram_access_sequencer_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start),
    .ram_ack (ram_ack),
    .ram_req (ram_req),
    .capture (capture),
    .busy    (busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_READY_CLEARS: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    start |=> !port_ready)
    else $error("ready still set after an accepted command");

  AST_READY_AFTER_DONE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    capture |=> port_ready)
    else $error("ready not back after the access completed");

  AST_LOW_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    capture_read |=> (low_q == $past(ram_rdata[DATA_WIDTH-1:0])))
    else $error("low word does not hold the fetched bits");

  AST_HIGH_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    capture_read && is_wide(op_choice_q) |=> (high_q == $past(ram_rdata[WORD_WIDTH-1:DATA_WIDTH])))
    else $error("high bits do not hold the fetched upper bits");

  AST_HIGH_NARROW_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    capture_read && !is_wide(op_choice_q) |=> (high_q == '0))
    else $error("high bits not zero after a narrow read");

  AST_WRITE_NARROW_DATA: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    ram_req && ram_write && !is_wide(op_choice_q) |-> (ram_wdata[WORD_WIDTH-1:DATA_WIDTH] == '0))
    else $error("narrow write carries high bits");

  AST_ONE_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    ram_req |-> $onehot(ram_enable))
    else $error("access not routed to exactly one RAM");
endmodule : internal_ram_test_data_port

////////////////////////////////////////////////////////////////////////////////
// One access: request pulse, then wait for the RAM's acknowledge
module ram_access_sequencer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic ram_ack,
  output logic      ram_req,
  output logic      capture,
  output logic      busy
);
  ram_port_pkg::port_state_type state_q;
  ram_port_pkg::port_state_type state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ram_port_pkg::ST_IDLE: begin
        if (start) begin
          state_d = ram_port_pkg::ST_ISSUE;
        end
      end
      ram_port_pkg::ST_ISSUE: begin
        state_d = ram_port_pkg::ST_WAIT;
      end
      ram_port_pkg::ST_WAIT: begin
        if (ram_ack) begin
          state_d = ram_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = ram_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ram_port_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign ram_req = (state_q == ram_port_pkg::ST_ISSUE);
  assign capture = (state_q == ram_port_pkg::ST_WAIT) & ram_ack;   // [RULE4]
  assign busy    = (state_q != ram_port_pkg::ST_IDLE);             // [RULE13]

  AST_REQ_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    ram_req |=> !ram_req)
    else $error("request held longer than one cycle");
endmodule : ram_access_sequencer
`default_nettype wire

// ===== sim/internal_ram_test_data_port_test.sv
// Bench for the RAM test data port, with a model of the RAMs behind it
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Four RAMs answering after a fixed latency; narrow RAMs drive noise up top
module ram_partner_model #(
  parameter int LATENCY = 6,
  parameter int DEPTH   = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  ram_enable,
  input  wire logic        ram_test_mode,
  input  wire logic        ram_req,
  input  wire logic        ram_write,
  input  wire logic [14:0] ram_addr,
  input  wire logic [36:0] ram_wdata,
  output logic      [36:0] ram_rdata,
  output logic             ram_ack,
  output logic      [36:0] last_wdata,
  output logic      [1:0]  last_ram,
  output logic      [14:0] last_addr,
  output int               req_count,
  output logic             mode_seen
);
  logic [36:0] mem [4][DEPTH];
  logic [1:0]  ram_index;
  int          wait_q;

  always_comb begin
    ram_index = 2'h0;
    for (int j = 0; j < 4; j++) begin
      if (ram_enable[j]) begin
        ram_index = 2'(j);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_ack    <= 1'b0;
      ram_rdata  <= 37'h00_0000_0000;
      wait_q     <= 0;
      req_count  <= 0;
      last_wdata <= 37'h00_0000_0000;
      last_ram   <= 2'h0;
      last_addr  <= 15'h0000;
      mode_seen  <= 1'b0;
    end else if (ram_req) begin
      req_count  <= req_count + 1;
      last_wdata <= ram_wdata;
      last_ram   <= ram_index;
      last_addr  <= ram_addr;
      mode_seen  <= ram_test_mode;
      wait_q     <= LATENCY;
      if (ram_write) begin
        mem[ram_index][ram_addr[3:0]] <= ram_wdata;
      end else if (ram_index < 2'h2) begin
        ram_rdata <= mem[ram_index][ram_addr[3:0]] | 37'h15_0000_0000;
      end else begin
        ram_rdata <= mem[ram_index][ram_addr[3:0]];
      end
    end else if (wait_q > 0) begin
      wait_q  <= wait_q - 1;
      ram_ack <= (wait_q == 1);
    end else begin
      ram_ack <= 1'b0;
    end
  end
endmodule : ram_partner_model

////////////////////////////////////////////////////////////////////////////////
module internal_ram_test_data_port_test;
  localparam int TIMEOUT_CYCLES = 20000;

  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        ram_test_mode;
  logic [3:0]  ram_enable;
  logic        ram_req;
  logic        ram_write;
  logic [14:0] ram_addr;
  logic [36:0] ram_wdata;
  logic [36:0] ram_rdata;
  logic        ram_ack;
  logic [36:0] last_wdata;
  logic [1:0]  last_ram;
  logic [14:0] last_addr;
  int          req_count;
  logic        mode_seen;
  logic [31:0] rd_word;
  int          n_errors    = 0;
  int          cmp_count   = 0;
  int          cycle_count = 0;

  always #20 pclk = ~pclk;

  internal_ram_test_data_port internal_ram_test_data_port_inst (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .ram_test_mode (ram_test_mode),
    .ram_enable    (ram_enable),
    .ram_req       (ram_req),
    .ram_write     (ram_write),
    .ram_addr      (ram_addr),
    .ram_wdata     (ram_wdata),
    .ram_rdata     (ram_rdata),
    .ram_ack       (ram_ack)
  );

  ram_partner_model ram_partner_model_inst (
    .pclk          (pclk),
    .presetn       (presetn),
    .ram_enable    (ram_enable),
    .ram_test_mode (ram_test_mode),
    .ram_req       (ram_req),
    .ram_write     (ram_write),
    .ram_addr      (ram_addr),
    .ram_wdata     (ram_wdata),
    .ram_rdata     (ram_rdata),
    .ram_ack       (ram_ack),
    .last_wdata    (last_wdata),
    .last_ram      (last_ram),
    .last_addr     (last_addr),
    .req_count     (req_count),
    .mode_seen     (mode_seen)
  );

  task automatic apb_write(input logic [7:0] addr, input logic [31:0] data);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= 1'b1;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_write

  task automatic apb_read(input logic [7:0] addr, output logic [31:0] data);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= addr;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    data = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_read

  task automatic check_value(input logic [63:0] got, input logic [63:0] expected);
    cmp_count++;
    if (got !== expected) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, expected);
    end
  endtask : check_value

  task automatic wait_ready();
    logic [31:0] status;
    status = 32'h0000_0000;
    while (status[ram_port_pkg::READY_BIT] !== 1'b1) apb_read(ram_port_pkg::OFS_SELECT, status);
  endtask : wait_ready

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  always @(posedge pclk) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == TIMEOUT_CYCLES) begin
      $display("Timeout after %0d cycles", cycle_count);
      n_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    apb_read(ram_port_pkg::OFS_SELECT, rd_word);
    check_value(rd_word, 32'h8000_0000);
    apb_read(ram_port_pkg::OFS_ADDRESS, rd_word);
    check_value(rd_word, 32'h0000_0000);
    apb_read(ram_port_pkg::OFS_LOW_WORD, rd_word);
    check_value(rd_word, 32'h0000_0000);
    apb_read(ram_port_pkg::OFS_HIGH_BITS, rd_word);
    check_value(rd_word, 32'h0000_0000);
    apb_read(ram_port_pkg::OFS_COMMAND, rd_word);
    check_value(rd_word, 32'h0000_0000);
    $display("Test reset values done");
    // Test mode on, transmit info RAM, wide write
    apb_write(ram_port_pkg::OFS_SELECT, 32'h0000_0005);
    apb_read(ram_port_pkg::OFS_SELECT, rd_word);
    check_value(rd_word, 32'h8000_0005);
    check_value(ram_test_mode, 1'b1);
    apb_write(ram_port_pkg::OFS_ADDRESS, 32'hFFFF_FFFF);
    apb_read(ram_port_pkg::OFS_ADDRESS, rd_word);
    check_value(rd_word, 32'h0000_7FFF);
    apb_write(ram_port_pkg::OFS_ADDRESS, 32'h0000_0003);
    apb_write(ram_port_pkg::OFS_LOW_WORD, 32'hA5A5_1234);
    apb_write(ram_port_pkg::OFS_HIGH_BITS, 32'hFFFF_FFFF);
    apb_read(ram_port_pkg::OFS_HIGH_BITS, rd_word);
    check_value(rd_word, 32'h0000_001F);
    apb_write(ram_port_pkg::OFS_COMMAND, 32'h0000_0001);
    apb_read(ram_port_pkg::OFS_SELECT, rd_word);
    check_value(rd_word, 32'h0000_0005);
    apb_write(ram_port_pkg::OFS_COMMAND, 32'h0000_0000);
    wait_ready();
    check_value(req_count, 1);
    check_value(last_wdata, 37'h1F_A5A5_1234);
    check_value(last_ram, 2'h2);
    check_value(last_addr, 15'h0003);
    check_value(mode_seen, 1'b1);
    apb_read(ram_port_pkg::OFS_COMMAND, rd_word);
    check_value(rd_word, 32'h0000_0001);
    // Wide read back
    apb_write(ram_port_pkg::OFS_LOW_WORD, 32'h0000_0000);
    apb_write(ram_port_pkg::OFS_HIGH_BITS, 32'h0000_0000);
    apb_write(ram_port_pkg::OFS_COMMAND, 32'h0000_0000);
    wait_ready();
    apb_read(ram_port_pkg::OFS_LOW_WORD, rd_word);
    check_value(rd_word, 32'hA5A5_1234);
    apb_read(ram_port_pkg::OFS_HIGH_BITS, rd_word);
    check_value(rd_word, 32'h0000_001F);
    check_value(req_count, 2);
    $display("Test wide RAM done");
    // Narrow FIFO control RAM
    apb_write(ram_port_pkg::OFS_SELECT, 32'h0000_0001);
    apb_write(ram_port_pkg::OFS_LOW_WORD, 32'hCAFE_0001);
    apb_write(ram_port_pkg::OFS_HIGH_BITS, 32'h0000_001F);
    apb_write(ram_port_pkg::OFS_COMMAND, 32'h0000_0001);
    wait_ready();
    check_value(last_wdata, 37'h00_CAFE_0001);
    check_value(last_ram, 2'h0);
    apb_write(ram_port_pkg::OFS_LOW_WORD, 32'h0000_0000);
    apb_write(ram_port_pkg::OFS_COMMAND, 32'h0000_0000);
    wait_ready();
    apb_read(ram_port_pkg::OFS_HIGH_BITS, rd_word);
    check_value(rd_word, 32'h0000_0000);
    apb_read(ram_port_pkg::OFS_LOW_WORD, rd_word);
    check_value(rd_word, 32'hCAFE_0001);
    // Storage and receive info RAMs
    apb_write(ram_port_pkg::OFS_SELECT, 32'h0000_0003);
    apb_write(ram_port_pkg::OFS_COMMAND, 32'h0000_0001);
    wait_ready();
    check_value(last_ram, 2'h1);
    apb_write(ram_port_pkg::OFS_SELECT, 32'h0000_0007);
    apb_write(ram_port_pkg::OFS_ADDRESS, 32'h0000_0005);
    apb_write(ram_port_pkg::OFS_LOW_WORD, 32'h1357_9BDF);
    apb_write(ram_port_pkg::OFS_HIGH_BITS, 32'h0000_000A);
    apb_write(ram_port_pkg::OFS_COMMAND, 32'h0000_0001);
    wait_ready();
    check_value(last_ram, 2'h3);
    check_value(last_wdata, 37'h0A_1357_9BDF);
    $display("Test narrow and other RAMs done");
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb_read(ram_port_pkg::OFS_SELECT, rd_word);
    check_value(rd_word, 32'h8000_0000);
    apb_read(ram_port_pkg::OFS_ADDRESS, rd_word);
    check_value(rd_word, 32'h0000_0000);
    $display("Test second reset done");
    stop_test();
  end
endmodule : internal_ram_test_data_port_test
`default_nettype wire
